// >>> design/fsam_mult.sv
// sequential shift-and-add multiplier for 40-bit two's-complement fractions
// assumes the controller holds operands steady in the start cycle
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - operands are sign plus 39 fraction bits; product is sign plus 78 bits
// - every word is a fraction with the point right of the sign bit
// - multiplier bits are examined one per step from the least significant
// - a one bit adds the multiplicand, then sum and multiplier shift right
// - a zero bit adds nothing; product and multiplier only shift right
// - forty steps: thirty-nine fraction steps then one correction step
// - final step adds the multiplicand complement when the multiplier is negative
// - the partial product starts at zero and stays zero until a first one
// - from the first one until the correction step the product sign copies the multiplicand sign
// - additions are modulo two; carry out of the sign is dropped
// - with rounding, bit 39 is set and lower bits dropped after step forty
// - rounding ignores bits from the rounding position on, then sets it
// - the complement is every bit inverted plus one at the lowest place
module fsam_mult
    import fsam_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        start,
    input  wire logic        round_en,
    input  wire logic [39:0] multiplicand,
    input  wire logic [39:0] multiplier,
    output var  logic        busy,
    output var  logic        done,
    output var  logic        corrected,
    output var  logic        rounded,
    output var  logic [39:0] product_hi,
    output var  logic [38:0] product_lo
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    fsam_state_t state;
    fsam_state_t next_state;
    logic [39:0] mcand;
    logic        mplier_sign;
    logic        round_req;
    logic        seen_one;

    // ----------------------------------------------------------------
    // step datapath wires
    // ----------------------------------------------------------------
    logic        take_start;
    logic        bit_now;
    logic        seen_now;
    logic        step_sign;
    logic [39:0] twice_p;
    logic [39:0] corr_p;
    logic [39:0] next_hi;
    logic [38:0] next_lo;

    fsam_add_if add_bus ();
    fsam_ctr_if ctr_bus ();

    fsam_adder u_adder (
        .add (add_bus.unit)
    );

    fsam_step_ctr u_ctr (
        .clk     (clk),
        .reset_n (reset_n),
        .ctr     (ctr_bus.unit)
    );

    // ----------------------------------------------------------------
    // request acceptance
    // ----------------------------------------------------------------
    assign take_start = start && (state == FSAM_IDLE);

    // ----------------------------------------------------------------
    // adder operands
    // ----------------------------------------------------------------
    always_comb begin
        add_bus.a        = product_hi;
        add_bus.b        = mcand;
        add_bus.invert_b = 1'b0;
        if (state == FSAM_CORR) begin
            add_bus.invert_b = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // step counter control
    // ----------------------------------------------------------------
    always_comb begin
        ctr_bus.clear   = take_start;
        ctr_bus.advance = (state == FSAM_FRAC);
    end

    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            FSAM_IDLE: begin
                if (take_start) begin
                    next_state = FSAM_FRAC;
                end
            end
            FSAM_FRAC: begin
                if (ctr_bus.last_frac) begin
                    next_state = FSAM_CORR;
                end
            end
            FSAM_CORR: begin
                next_state = FSAM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= FSAM_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // fraction step
    // ----------------------------------------------------------------
    // the doubled sum keeps its mod-2 top bit as the new half bit;
    // only the sign of the shifted word is taken from the multiplicand
    always_comb begin
        bit_now   = product_lo[0];
        seen_now  = seen_one | bit_now;
        twice_p   = product_hi;
        if (bit_now) begin
            twice_p = add_bus.sum;
        end
        step_sign = twice_p[SIGN_POS];
        if (seen_now) begin
            step_sign = mcand[SIGN_POS];
        end
    end

    // ----------------------------------------------------------------
    // correction and rounding step
    // ----------------------------------------------------------------
    always_comb begin
        corr_p = product_hi;
        if (mplier_sign) begin
            corr_p = add_bus.sum;
        end
    end

    // ----------------------------------------------------------------
    // next product words
    // ----------------------------------------------------------------
    always_comb begin
        next_hi = product_hi;
        next_lo = product_lo;
        unique case (state)
            FSAM_IDLE: begin
                if (take_start) begin
                    next_hi = WORD_RST;
                    next_lo = multiplier[FRAC_W-1:0];
                end
            end
            FSAM_FRAC: begin
                next_hi = {step_sign, twice_p[WORD_W-1:1]};
                next_lo = {twice_p[0], product_lo[FRAC_W-1:1]};
            end
            FSAM_CORR: begin
                next_hi = corr_p;
                if (round_req) begin
                    next_hi = {corr_p[WORD_W-1:1], 1'b1};
                    next_lo = FRAC_RST;
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // product registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            product_hi <= WORD_RST;
            product_lo <= FRAC_RST;
        end else begin
            product_hi <= next_hi;
            product_lo <= next_lo;
        end
    end

    // ----------------------------------------------------------------
    // operand capture
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mcand       <= WORD_RST;
            mplier_sign <= 1'b0;
            round_req   <= 1'b0;
        end else if (take_start) begin
            mcand       <= multiplicand;
            mplier_sign <= multiplier[SIGN_POS];
            round_req   <= round_en;
        end
    end

    // ----------------------------------------------------------------
    // first-one tracking
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            seen_one <= 1'b0;
        end else if (take_start) begin
            seen_one <= 1'b0;
        end else if (state == FSAM_FRAC) begin
            seen_one <= seen_now;
        end
    end

    // ----------------------------------------------------------------
    // status
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            busy <= 1'b0;
        end else if (take_start) begin
            busy <= 1'b1;
        end else if (state == FSAM_CORR) begin
            busy <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            done <= 1'b0;
        end else if (take_start) begin
            done <= 1'b0;
        end else if (state == FSAM_CORR) begin
            done <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            corrected <= 1'b0;
            rounded   <= 1'b0;
        end else if (take_start) begin
            corrected <= 1'b0;
            rounded   <= 1'b0;
        end else if (state == FSAM_CORR) begin
            corrected <= mplier_sign;
            rounded   <= round_req;
        end
    end
endmodule
`default_nettype wire

// >>> design/fsam_pkg.sv
// constants shared by the fraction shift-and-add multiplier
// assumes a single clock domain and a synchronous active-low reset
package fsam_pkg;

    // ----------------------------------------------------------------
    // word layout
    // ----------------------------------------------------------------
    localparam int          WORD_W     = 40;
    localparam int          FRAC_W     = 39;
    localparam int          SIGN_POS   = 39;
    localparam int          STEP_W     = 6;

    // ----------------------------------------------------------------
    // step counts
    // ----------------------------------------------------------------
    localparam logic [5:0]  FRAC_STEPS = 6'h27;
    localparam logic [5:0]  LAST_FRAC  = 6'h26;
    localparam logic [5:0]  ALL_STEPS  = 6'h28;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [39:0] WORD_RST   = 40'h00_0000_0000;
    localparam logic [38:0] FRAC_RST   = 39'h00_0000_0000;
    localparam logic [5:0]  COUNT_RST  = 6'h00;

    typedef enum logic [1:0] {
        FSAM_IDLE,
        FSAM_FRAC,
        FSAM_CORR
    } fsam_state_t;

endpackage

// >>> design/fsam_link_if.sv
// interfaces joining the multiplier core to its adder and step counter
// assumes all parties run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface fsam_add_if;
    logic [39:0] a;
    logic [39:0] b;
    logic        invert_b;
    logic [39:0] sum;
    modport user (output a, output b, output invert_b, input sum);
    modport unit (input a, input b, input invert_b, output sum);
endinterface

interface fsam_ctr_if;
    logic       clear;
    logic       advance;
    logic [5:0] count;
    logic       last_frac;
    modport user (output clear, output advance, input count, input last_frac);
    modport unit (input clear, input advance, output count, output last_frac);
endinterface
`default_nettype wire

// >>> design/fsam_adder.sv
// forty-bit modulo-2 adder with optional complement of the b operand
// assumes a purely combinational use inside the multiplier core
`timescale 1ns/1ps
`default_nettype none
module fsam_adder
    import fsam_pkg::*;
(
    fsam_add_if.unit add
);
    logic [39:0] b_eff;

    // ----------------------------------------------------------------
    // reflect and add one for the complement, carry out dropped
    // ----------------------------------------------------------------
    assign b_eff   = add.invert_b ? ~add.b : add.b;
    assign add.sum = add.a + b_eff + {39'h0, add.invert_b};
endmodule
`default_nettype wire

// >>> design/fsam_step_ctr.sv
// step counter for the multiplier sequence
// assumes clear and advance come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module fsam_step_ctr
    import fsam_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset_n,
    fsam_ctr_if.unit  ctr
);
    // ----------------------------------------------------------------
    // count of fractional steps done
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctr.count <= COUNT_RST;
        end else if (ctr.clear) begin
            ctr.count <= COUNT_RST;
        end else if (ctr.advance) begin
            ctr.count <= ctr.count + 6'h01;
        end
    end

    assign ctr.last_frac = (ctr.count == LAST_FRAC);
endmodule
`default_nettype wire

// >>> testbench/fsam_mult_chk.sv
// port assertions for the fraction multiplier
// assumes one clock and the synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module fsam_mult_chk
    import fsam_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        start,
    input wire logic        round_en,
    input wire logic [39:0] multiplicand,
    input wire logic [39:0] multiplier,
    input wire logic        busy,
    input wire logic        done,
    input wire logic        corrected,
    input wire logic        rounded,
    input wire logic [39:0] product_hi,
    input wire logic [38:0] product_lo
);
    logic [6:0]  busy_cnt;
    logic        y_sign;
    logic [38:0] x_lo;
    logic        x_sign;
    logic        take;
    logic [37:0] lo_top;
    assign x_lo   = multiplier[38:0];
    assign x_sign = multiplier[39];
    assign take   = start && !busy;
    assign lo_top = product_lo[38:1];
    always_ff @(posedge clk) begin
        busy_cnt <= (busy && reset_n) ? busy_cnt + 7'h01 : 7'h00;
    end
    always_ff @(posedge clk) begin
        if (take) begin
            y_sign <= multiplicand[39];
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    accept_load_a: assert property (take |=> busy && !done && product_hi == 40'h00_0000_0000
        && product_lo == $past(x_lo)) else $error("bad state after start");
    busy_span_a: assert property ($fell(busy) && $past(reset_n) |-> busy_cnt == 7'h28)
        else $error("busy span wrong");
    done_time_a: assert property (take |-> ##41 (done && !busy))
        else $error("done late or early");
    flags_a: assert property (take |-> ##41 (corrected == $past(x_sign, 41)
        && rounded == $past(round_en, 41))) else $error("flags wrong");
    done_hold_a: assert property (done && !start |=> done && $stable(product_hi)
        && $stable(product_lo)) else $error("result not held");
    round_form_a: assert property (done && rounded |-> product_hi[0]
        && product_lo == 39'h00_0000_0000) else $error("rounding form wrong");
    shift_step_a: assert property (busy && $past(busy) |->
        product_lo[37:0] == $past(lo_top)) else $error("shift wrong");
    sign_force_a: assert property (busy && $past(busy) && product_hi != 40'h00_0000_0000
        |-> product_hi[39] == y_sign) else $error("sign not forced");
endmodule
bind fsam_mult fsam_mult_chk chk (.*);
`default_nettype wire

// >>> testbench/fsam_ctl.sv
// controller model: loads operands and pulses start
// assumes operands matter only on the start edge
`timescale 1ns/1ps
`default_nettype none
module fsam_ctl
    import fsam_pkg::*;
(
    input  wire logic        clk,
    output var  logic        start,
    output var  logic        round_en,
    output var  logic [39:0] multiplicand,
    output var  logic [39:0] multiplier
);
    initial begin
        start = 1'b0;
        round_en = 1'b0;
        multiplicand = 40'h00_0000_0000;
        multiplier = 40'h00_0000_0000;
    end
    task automatic go(input logic [39:0] y, input logic [39:0] x, input logic r);
        @(posedge clk);
        start        <= 1'b1;
        round_en     <= r;
        multiplicand <= y;
        multiplier   <= x;
        @(posedge clk);
        start        <= 1'b0;
        round_en     <= ~r;
        multiplicand <= ~y;
        multiplier   <= ~x;
        #1;
    endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the fraction multiplier
// assumes the controller model drives start and operands
`timescale 1ns/1ps
`default_nettype none
module tb
    import fsam_pkg::*;
;
    logic        clk;
    logic        reset_n;
    logic        start;
    logic        round_en;
    logic [39:0] y;
    logic [39:0] x;
    logic        busy;
    logic        done;
    logic        corrected;
    logic        rounded;
    logic [39:0] hi;
    logic [38:0] lo;
    int          bad_count;
    int          n_checks;
    fsam_mult dut (.clk(clk), .reset_n(reset_n), .start(start), .round_en(round_en),
        .multiplicand(y), .multiplier(x), .busy(busy), .done(done), .corrected(corrected),
        .rounded(rounded), .product_hi(hi), .product_lo(lo));
    fsam_ctl ctl (.clk(clk), .start(start), .round_en(round_en), .multiplicand(y),
        .multiplier(x));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk_val(input logic [78:0] got, input logic [78:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    function automatic logic [78:0] exp_prod(input logic [39:0] a, input logic [39:0] b,
        input logic r);
        logic [79:0] p;
        p = $signed(a) * $signed(b);
        if (r) begin
            p[39:0] = 40'h80_0000_0000;
        end
        return p[78:0];
    endfunction
    task automatic wait_done(output int n);
        n = 0;
        while (done !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    task automatic mul(input logic [39:0] a, input logic [39:0] b, input logic r);
        int n;
        ctl.go(a, b, r);
        wait_done(n);
        chk_val(79'(n), 79'h28);
        chk_val({hi, lo}, exp_prod(a, b, r));
        chk_val(79'({corrected, rounded}), 79'({b[39], r}));
    endtask
    task automatic t_products;
        logic [39:0] ys [7] = '{40'h90_0000_0000, 40'ha0_0000_0000, 40'h7f_ffff_ffff,
            40'h00_0000_0000, 40'h12_3456_789a, 40'hc3_5a69_0f1e, 40'h80_0000_0000};
        logic [39:0] xs [7] = '{40'h70_0000_0000, 40'hd0_0000_0000, 40'h80_0000_0000,
            40'hff_ffff_ffff, 40'h00_0000_0001, 40'hb7_1d2e_4c85, 40'h7f_ffff_ffff};
        for (int i = 0; i < 7; i++) begin
            mul(ys[i], xs[i], 1'b0);
            mul(ys[i], xs[i], 1'b1);
        end
        $display("test products finished");
    endtask
    task automatic t_refuse;
        int n;
        ctl.go(40'h40_0000_0000, 40'hc0_0000_0001, 1'b0);
        repeat (10) @(posedge clk);
        ctl.go(40'h11_1111_1111, 40'h22_2222_2222, 1'b1);
        wait_done(n);
        chk_val(79'(n), 79'h1c);
        chk_val({hi, lo}, exp_prod(40'h40_0000_0000, 40'hc0_0000_0001, 1'b0));
        chk_val(79'({corrected, rounded}), 79'h2);
        repeat (3) @(posedge clk);
        #1;
        chk_val(79'(done), 79'h1);
        $display("test refuse finished");
    endtask
    task automatic t_reset;
        ctl.go(40'h5a_5a5a_5a5a, 40'ha5_a5a5_a5a5, 1'b1);
        repeat (20) @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk_val({hi, lo}, 79'h0);
        chk_val(79'({busy, done, corrected, rounded}), 79'h0);
        mul(40'h5a_5a5a_5a5a, 40'ha5_a5a5_a5a5, 1'b1);
        $display("test reset finished");
    endtask
    initial begin
        bad_count = 0;
        n_checks = 0;
        reset_n = 1'b0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        t_products();
        t_refuse();
        t_reset();
        give_verdict();
    end
    initial begin
        #(50 * 2000);
        bad_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
